// [core/evd_decoder.sv]
`timescale 1ns/1ps
// Summary of operation
// - each input takes one of eleven functions
// - duplicate non-none function assignments are refused
// - level accepted after 50 ms, logic 250 ms
// - input on stops control, off runs
// - stop indicator follows stopped state
// - input on selects manual, off automatic
// - manual indicator follows manual selection
// - on starts program, off resets and stops
// - program reset clears program end output
// - program start ignored while pattern off
// - input on inverts configured control direction
// - on selects remote setpoint, off local
// - remote indicator follows remote setpoint mode
// - remote setpoint function only where supported
// - on runs full autotune, off cancels
// - on runs partial autotune, off cancels
// - partial autotune inactive under heating/cooling
// - on locks setting changes, off permits
// - link write only inputs three, four
// - link write needs comms, no work bit
// - rising input clears every latched alarm
// - inputs three, four take functions only when fitted
// - bank-select inputs carry no function
module evd_decoder #(
	parameter int SHORT_CYC = evd_pkg::EVD_SHORT_CYC,
	parameter int LONG_CYC = evd_pkg::EVD_LONG_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] contact_in,
	input wire logic prog_end_set,
	output evd_pkg::evd_cmd_s cmd,
	output logic prog_end,
	output logic stop_ind,
	output logic hand_ind,
	output logic far_ind,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import evd_pkg::*;

	// ****************************************
	// input synchronisers and stability filters
	// ****************************************
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic [3:0] fast_r;
	logic [3:0] slow_r;
	logic [3:0] fast_prev_r;
	logic [3:0] slow_prev_r;
	logic [31:0] cnt_r [4];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
		end else begin
			sync1_r <= contact_in;
			sync2_r <= sync1_r;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fast_r <= 4'h0;
			slow_r <= 4'h0;
			for (int i = 0; i < 4; i++) begin
				cnt_r[i] <= 32'h0000_0000;
			end
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (sync2_r[i] == slow_r[i]) begin
					cnt_r[i] <= 32'h0000_0000;
					fast_r[i] <= slow_r[i];
				end else begin
					cnt_r[i] <= cnt_r[i] + 32'h0000_0001;
					if (cnt_r[i] >= 32'(SHORT_CYC - 1)) begin
						fast_r[i] <= sync2_r[i];
					end
					if (cnt_r[i] >= 32'(LONG_CYC - 1)) begin
						slow_r[i] <= sync2_r[i];
						cnt_r[i] <= 32'h0000_0000;
					end
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fast_prev_r <= 4'h0;
			slow_prev_r <= 4'h0;
		end else begin
			fast_prev_r <= fast_r;
			slow_prev_r <= slow_r;
		end
	end

	// ****************************************
	// registers
	// ****************************************
	logic [31:0] assign_r;
	logic [31:0] cfg_r;
	logic aw_held_r;
	logic w_held_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [31:0] wr_merge;
	logic wr_fire;
	logic wr_ok;
	logic [1:0] banks;

	assign banks = cfg_r[EVD_CFG_BANKS_LSB +: 2];
	assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready = !w_held_r && !s_axi_bvalid;
	assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;

	always_comb begin
		wr_merge = assign_r;
		for (int b = 0; b < 4; b++) begin
			if (wstrb_r[b]) begin
				wr_merge[8*b +: 8] = wdata_r[8*b +: 8];
			end
		end
	end

	// legality check of a proposed assignment word
	function automatic logic assign_legal(input logic [31:0] w, input logic [31:0] c);
		logic ok;
		logic [3:0] f;
		logic [3:0] g;
		ok = 1'b1;
		for (int i = 0; i < 4; i++) begin
			f = w[4*i +: 4];
			if (f > EVD_FN_LATCH_CLR) ok = 1'b0;
			if (f == EVD_FN_FAR_SP && !c[EVD_CFG_HAS_FAR]) ok = 1'b0;
			// link write on inputs three, four
			if (f == EVD_FN_LINK_WR && i < 2) ok = 1'b0;
			// link write needs comms, no work bit
			if (f == EVD_FN_LINK_WR && (!c[EVD_CFG_HAS_LINK] || c[EVD_CFG_WORK_BIT])) ok = 1'b0;
			if (i >= 2 && f != EVD_FN_NONE && !c[EVD_CFG_HAS_HI]) ok = 1'b0;
			for (int j = 0; j < i; j++) begin
				g = w[4*j +: 4];
				if (f != EVD_FN_NONE && f == g) ok = 1'b0;
			end
		end
		return ok;
	endfunction

	assign wr_ok = (awaddr_r == EVD_ADDR_ASSIGN) ? assign_legal(wr_merge, cfg_r)
		: (awaddr_r == EVD_ADDR_CONFIG);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_r <= 1'b1;
				awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
			end else if (wr_fire) begin
				aw_held_r <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			assign_r <= EVD_ASSIGN_RST;
			cfg_r <= EVD_CFG_RST;
		end else if (wr_fire && wr_ok) begin
			if (awaddr_r == EVD_ADDR_ASSIGN) begin
				assign_r <= wr_merge;
			end else begin
				for (int b = 0; b < 4; b++) begin
					if (wstrb_r[b]) cfg_r[8*b +: 8] <= wdata_r[8*b +: 8];
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= EVD_RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? EVD_RESP_OKAY : EVD_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= EVD_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= EVD_RESP_OKAY;
			unique case ({s_axi_araddr[7:2], 2'b00})
				EVD_ADDR_ASSIGN: s_axi_rdata <= assign_r;
				EVD_ADDR_CONFIG: s_axi_rdata <= cfg_r;
				EVD_ADDR_STATUS: s_axi_rdata <= {20'h0_0000, prog_end, cmd};
				EVD_ADDR_INPUTS: s_axi_rdata <= {24'h00_0000, slow_r, fast_r};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= EVD_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// function decode
	// ****************************************
	logic [3:0] fn_lv;
	logic [3:0] fn_rise;
	logic [3:0] fn_fall;
	logic [3:0] used;

	// lowest inputs of the fitted pair go to banks
	always_comb begin
		used = 4'hf;
		for (int i = 0; i < 4; i++) begin
			if (cfg_r[EVD_CFG_HAS_HI] ? (i >= 2 ? i - 2 : 4) < 32'(banks) : i < 32'(banks))
				used[i] = 1'b0;
			// three banks take inputs one to three, input four stays free
			if (cfg_r[EVD_CFG_HAS_HI] && banks == 2'h3) used[i] = (i == 3);
		end
	end

	// short filter drives commands; long filter only read back at the inputs address
	assign fn_lv = fast_r & used;
	assign fn_rise = fast_r & ~fast_prev_r & used;
	assign fn_fall = ~fast_r & fast_prev_r & used;

	function automatic logic [3:0] hits(input logic [31:0] w, input evd_fn_e f);
		logic [3:0] h;
		h = 4'h0;
		for (int i = 0; i < 4; i++) h[i] = (w[4*i +: 4] == f);
		return h;
	endfunction

	logic seq_on;
	logic seq_off;
	logic seq_stop_r;

	// program start ignored without a pattern
	assign seq_on = cfg_r[EVD_CFG_PROG_EN] && |(fn_rise & hits(assign_r, EVD_FN_SEQ));
	assign seq_off = cfg_r[EVD_CFG_PROG_EN] && |(fn_fall & hits(assign_r, EVD_FN_SEQ));

	// program reset forces stop until restarted
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seq_stop_r <= 1'b0;
		end else if (seq_on) begin
			seq_stop_r <= 1'b0;
		end else if (seq_off) begin
			seq_stop_r <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prog_end <= 1'b0;
		end else if (seq_off) begin
			prog_end <= 1'b0;
		end else if (prog_end_set) begin
			prog_end <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd <= '0;
		end else begin
			cmd.stopped <= |(fn_lv & hits(assign_r, EVD_FN_RUN_STOP)) || seq_stop_r || seq_off;
			cmd.hand <= |(fn_lv & hits(assign_r, EVD_FN_HAND));
			cmd.seq_run <= seq_on || (cmd.seq_run && !seq_off);
			cmd.seq_reset <= seq_off;
			cmd.direct_act <= !cfg_r[EVD_CFG_REVERSE] ^ |(fn_lv & hits(assign_r, EVD_FN_INVERT));
			cmd.far_sp <= |(fn_lv & hits(assign_r, EVD_FN_FAR_SP));
			cmd.at_full <= |(fn_lv & hits(assign_r, EVD_FN_AT_FULL));
			cmd.at_part <= |(fn_lv & hits(assign_r, EVD_FN_AT_PART)) && !cfg_r[EVD_CFG_HEATCOOL];
			cmd.edit_locked <= |(fn_lv & hits(assign_r, EVD_FN_EDIT_LOCK));
			cmd.link_wr_ok <= |(fn_lv & hits(assign_r, EVD_FN_LINK_WR) & 4'hc);
			cmd.latch_clear <= |(fn_rise & hits(assign_r, EVD_FN_LATCH_CLR));
		end
	end

	assign stop_ind = cmd.stopped;
	assign hand_ind = cmd.hand;
	assign far_ind = cmd.far_sp;

	// ****************************************
	// checks
	// ****************************************
	// duplicates only: a config write may legally leave other limits stale
	logic assign_dup;
	always_comb begin
		assign_dup = 1'b0;
		for (int i = 1; i < 4; i++) begin
			for (int j = 0; j < i; j++) begin
				if (assign_r[4*i +: 4] != EVD_FN_NONE && assign_r[4*i +: 4] == assign_r[4*j +: 4])
					assign_dup = 1'b1;
			end
		end
	end

	a_sync_reset_off: assert property (@(posedge aclk) !aresetn |=> fast_r == 4'h0)
		else $error("filtered inputs not off after reset");
	a_filter_no_early: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(fast_r[0]) |-> cnt_r[0] == 32'(SHORT_CYC))
		else $error("input accepted before filter time");
	a_stop_ind_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		seq_stop_r |=> stop_ind)
		else $error("stop indicator wrong");
	a_seq_reset_end: assert property (@(posedge aclk) disable iff (!aresetn)
		seq_off |=> !prog_end && cmd.stopped)
		else $error("program reset left end or run");
	a_part_heatcool: assert property (@(posedge aclk) disable iff (!aresetn)
		cfg_r[EVD_CFG_HEATCOOL] && $stable(cfg_r) |=> !cmd.at_part)
		else $error("partial autotune under heating/cooling");
	a_no_dup_assign: assert property (@(posedge aclk) disable iff (!aresetn)
		!assign_dup)
		else $error("illegal assignment stored");
	a_hand_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(fn_lv[1]) && assign_r[7:4] == EVD_FN_HAND && $stable(assign_r) |=> cmd.hand)
		else $error("manual not selected");
	a_latch_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
		cmd.latch_clear |=> !cmd.latch_clear)
		else $error("latch clear longer than a pulse");
	a_link_low_in: assert property (@(posedge aclk) disable iff (!aresetn)
		assign_r[3:0] != EVD_FN_LINK_WR && assign_r[7:4] != EVD_FN_LINK_WR)
		else $error("link write on input one or two");

endmodule

// [core/evd_pkg.sv]
package evd_pkg;

	// function codes held in each assignment register
	typedef enum logic [3:0] {
		EVD_FN_NONE = 4'h0,
		EVD_FN_RUN_STOP = 4'h1,
		EVD_FN_HAND = 4'h2,
		EVD_FN_SEQ = 4'h3,
		EVD_FN_INVERT = 4'h4,
		EVD_FN_FAR_SP = 4'h5,
		EVD_FN_AT_FULL = 4'h6,
		EVD_FN_AT_PART = 4'h7,
		EVD_FN_EDIT_LOCK = 4'h8,
		EVD_FN_LINK_WR = 4'h9,
		EVD_FN_LATCH_CLR = 4'ha
	} evd_fn_e;

	localparam int EVD_NUM_IN = 4;

	localparam logic [7:0] EVD_ADDR_ASSIGN = 8'h00;
	localparam logic [7:0] EVD_ADDR_CONFIG = 8'h04;
	localparam logic [7:0] EVD_ADDR_STATUS = 8'h08;
	localparam logic [7:0] EVD_ADDR_INPUTS = 8'h0c;

	// assignment word: 4 bits per input, input n at bits 4n+3:4n
	localparam int EVD_FN_W = 4;
	// config word fields
	localparam int EVD_CFG_BANKS_LSB = 0;
	localparam int EVD_CFG_PROG_EN = 2;
	localparam int EVD_CFG_HEATCOOL = 3;
	localparam int EVD_CFG_REVERSE = 4;
	localparam int EVD_CFG_HAS_FAR = 5;
	localparam int EVD_CFG_HAS_LINK = 6;
	localparam int EVD_CFG_WORK_BIT = 7;
	localparam int EVD_CFG_HAS_HI = 8;
	localparam logic [31:0] EVD_CFG_RST = 32'h0000_0001;
	localparam logic [31:0] EVD_ASSIGN_RST = 32'h0000_0000;

	localparam logic [1:0] EVD_RESP_OKAY = 2'b00;
	localparam logic [1:0] EVD_RESP_SLVERR = 2'b10;

	localparam int EVD_CLK_HZ = 50_000_000;
	localparam int EVD_SHORT_MS = 50;
	localparam int EVD_LONG_MS = 250;
	localparam int EVD_SHORT_CYC = EVD_CLK_HZ / 1000 * EVD_SHORT_MS;
	localparam int EVD_LONG_CYC = EVD_CLK_HZ / 1000 * EVD_LONG_MS;

	typedef struct packed {
		logic stopped;
		logic hand;
		logic seq_run;
		logic seq_reset;
		logic direct_act;
		logic far_sp;
		logic at_full;
		logic at_part;
		logic edit_locked;
		logic link_wr_ok;
		logic latch_clear;
	} evd_cmd_s;

endpackage

// [sim/evd_contacts.sv]
`timescale 1ns/1ps
// ************************************************
// switch contacts on the event inputs
// ************************************************
module evd_contacts #(
	parameter int HOLD = 40
) (
	input wire logic aclk,
	input wire logic [3:0] want,
	output logic [3:0] contact_in
);
	import evd_pkg::*;
	int held;
	initial begin
		contact_in = 4'h0;
		held = 0;
	end
	// hold each level
	// a flip waits out the slow window so no level is ever shorter than the filter
	always @(posedge aclk) begin
		if (want != contact_in && held >= HOLD) begin
			contact_in <= want;
			held <= 0;
		end else if (held < HOLD) begin
			held <= held + 1;
		end
	end
endmodule

// [sim/evd_decoder_tb.sv]
`timescale 1ns/1ps
module evd_decoder_tb;
	import evd_pkg::*;
	localparam int SHORT = 8;
	localparam int LONG = 40;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] want = 4'h0;
	logic prog_end_set = 1'b0;
	logic [3:0] contact_in;
	evd_cmd_s cmd;
	logic prog_end, stop_ind, hand_ind, far_ind;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1;
	logic s_axi_rready = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	int mismatches = 0;
	int samples_checked = 0;
	logic [31:0] clears = 32'h0000_0000;
	logic [31:0] resets = 32'h0000_0000;
	logic [31:0] c0;
	logic [31:0] fn_exp [0:9] = '{32'h0000_0040, 32'h0000_0440, 32'h0000_0240, 32'h0000_0000,
		32'h0000_0000, 32'h0000_0060, 32'h0000_0050, 32'h0000_0048, 32'h0000_0044, 32'h0000_0044};

	evd_decoder #(.SHORT_CYC(SHORT), .LONG_CYC(LONG)) evd_decoder_inst (.aclk, .aresetn,
		.contact_in, .prog_end_set, .cmd, .prog_end, .stop_ind, .hand_ind, .far_ind,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);
	evd_contacts #(.HOLD(LONG)) evd_contacts_inst (.aclk, .want, .contact_in);

	always #10 aclk = ~aclk;
	always @(posedge aclk) begin
		if (cmd.latch_clear === 1'b1) begin
			clears <= clears + 32'h0000_0001;
		end
		if (cmd.seq_reset === 1'b1) begin
			resets <= resets + 32'h0000_0001;
		end
	end

	// ************************************************
	// compares and bus cycles
	// ************************************************
	task chk_word(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task chk_resp(input logic [1:0] got, input logic [1:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// bready stays high throughout, so a response is taken the edge it shows
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw_hs, w_hs, b_hs;
		logic [1:0] r;
		aw_hs = 1'b0;
		w_hs = 1'b0;
		b_hs = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!b_hs) begin
			#1;
			if (s_axi_awvalid && s_axi_awready) aw_hs = 1'b1;
			if (s_axi_wvalid && s_axi_wready) w_hs = 1'b1;
			if (s_axi_bvalid) begin
				b_hs = 1'b1;
				r = s_axi_bresp;
			end
			@(posedge aclk);
			if (aw_hs && s_axi_awvalid) s_axi_awvalid <= 1'b0;
			if (w_hs && s_axi_wvalid) s_axi_wvalid <= 1'b0;
		end
		if (er !== 2'bxx) chk_resp(r, er);
	endtask
	task chk_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		logic ar_hs, done;
		logic [31:0] d;
		logic [1:0] r;
		ar_hs = 1'b0;
		done = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (!done) begin
			#1;
			if (s_axi_arvalid && s_axi_arready) ar_hs = 1'b1;
			if (s_axi_rvalid) begin
				done = 1'b1;
				d = s_axi_rdata;
				r = s_axi_rresp;
			end
			@(posedge aclk);
			if (ar_hs && s_axi_arvalid) s_axi_arvalid <= 1'b0;
		end
		chk_word(d, exp);
		chk_resp(r, er);
	endtask
	task settle;
		repeat (2 * LONG + SHORT + 8) @(posedge aclk);
	endtask
	task results;
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		// run needs about 1200 cycles; this allows several times that
		#200_000;
		mismatches++;
		results;
	end

	// ************************************************
	// tests
	// ************************************************
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_rd(EVD_ADDR_ASSIGN, EVD_ASSIGN_RST, EVD_RESP_OKAY);
		chk_rd(EVD_ADDR_CONFIG, EVD_CFG_RST, EVD_RESP_OKAY);
		chk_rd(8'h10, 32'h0000_0000, EVD_RESP_SLVERR);
		wr(EVD_ADDR_STATUS, 32'h0000_0001, EVD_RESP_SLVERR);
		wr(EVD_ADDR_CONFIG, 32'h0000_0160, EVD_RESP_OKAY);
		wr(EVD_ADDR_ASSIGN, 32'h0000_0003, EVD_RESP_OKAY);
		want <= 4'h1;
		settle;
		chk_rd(EVD_ADDR_STATUS, 32'h0000_0040, EVD_RESP_OKAY);
		wr(EVD_ADDR_CONFIG, 32'h0000_0164, EVD_RESP_OKAY);
		wr(EVD_ADDR_ASSIGN, 32'h0000_5921, EVD_RESP_OKAY);
		want <= 4'hb;
		settle;
		chk_rd(EVD_ADDR_STATUS, 32'h0000_0660, EVD_RESP_OKAY);
		chk_word({29'h0000_0000, stop_ind, hand_ind, far_ind}, 32'h0000_0007);
		chk_rd(EVD_ADDR_INPUTS, 32'h0000_00bb, EVD_RESP_OKAY);
		want <= 4'h7;
		settle;
		chk_rd(EVD_ADDR_STATUS, 32'h0000_0642, EVD_RESP_OKAY);
		wr(EVD_ADDR_ASSIGN, 32'h0000_5911, EVD_RESP_SLVERR);
		wr(EVD_ADDR_ASSIGN, 32'h0000_0529, EVD_RESP_SLVERR);
		chk_rd(EVD_ADDR_ASSIGN, 32'h0000_5921, EVD_RESP_OKAY);
		want <= 4'h2;
		settle;
		for (int c = 0; c < 10; c++) begin
			if (c != 3) begin
				wr(EVD_ADDR_ASSIGN, {24'h00_0000, 4'(c), 4'h0}, (c == 9) ? EVD_RESP_SLVERR : EVD_RESP_OKAY);
				chk_rd(EVD_ADDR_STATUS, fn_exp[c], EVD_RESP_OKAY);
			end
		end
		wr(EVD_ADDR_CONFIG, 32'h0000_0174, EVD_RESP_OKAY);
		wr(EVD_ADDR_ASSIGN, 32'h0000_0040, EVD_RESP_OKAY);
		chk_rd(EVD_ADDR_STATUS, 32'h0000_0040, EVD_RESP_OKAY);
		wr(EVD_ADDR_CONFIG, 32'h0000_0144, EVD_RESP_OKAY);
		wr(EVD_ADDR_ASSIGN, 32'h0000_0050, EVD_RESP_SLVERR);
		wr(EVD_ADDR_CONFIG, 32'h0000_01e4, EVD_RESP_OKAY);
		wr(EVD_ADDR_ASSIGN, 32'h0000_0900, EVD_RESP_SLVERR);
		wr(EVD_ADDR_CONFIG, 32'h0000_0124, EVD_RESP_OKAY);
		wr(EVD_ADDR_ASSIGN, 32'h0000_0900, EVD_RESP_SLVERR);
		wr(EVD_ADDR_CONFIG, 32'h0000_016c, EVD_RESP_OKAY);
		wr(EVD_ADDR_ASSIGN, 32'h0000_0070, EVD_RESP_OKAY);
		chk_rd(EVD_ADDR_STATUS, 32'h0000_0040, EVD_RESP_OKAY);
		wr(EVD_ADDR_CONFIG, 32'h0000_0164, EVD_RESP_OKAY);
		wr(EVD_ADDR_ASSIGN, 32'h0000_00a0, EVD_RESP_OKAY);
		want <= 4'h0;
		settle;
		c0 = clears;
		want <= 4'h2;
		settle;
		chk_word(clears - c0, 32'h0000_0001);
		want <= 4'h0;
		settle;
		wr(EVD_ADDR_CONFIG, 32'h0000_0065, EVD_RESP_OKAY);
		wr(EVD_ADDR_ASSIGN, 32'h0000_0001, EVD_RESP_OKAY);
		want <= 4'h1;
		settle;
		chk_rd(EVD_ADDR_STATUS, 32'h0000_0040, EVD_RESP_OKAY);
		wr(EVD_ADDR_CONFIG, 32'h0000_0165, EVD_RESP_OKAY);
		chk_rd(EVD_ADDR_STATUS, 32'h0000_0440, EVD_RESP_OKAY);
		wr(EVD_ADDR_CONFIG, 32'h0000_0167, EVD_RESP_OKAY);
		chk_rd(EVD_ADDR_STATUS, 32'h0000_0040, EVD_RESP_OKAY);
		want <= 4'h0;
		settle;
		wr(EVD_ADDR_CONFIG, 32'h0000_0164, EVD_RESP_OKAY);
		wr(EVD_ADDR_ASSIGN, 32'h0000_0003, EVD_RESP_OKAY);
		want <= 4'h1;
		settle;
		chk_rd(EVD_ADDR_STATUS, 32'h0000_0140, EVD_RESP_OKAY);
		prog_end_set <= 1'b1;
		@(posedge aclk);
		prog_end_set <= 1'b0;
		@(posedge aclk);
		chk_rd(EVD_ADDR_STATUS, 32'h0000_0940, EVD_RESP_OKAY);
		c0 = resets;
		want <= 4'h0;
		settle;
		chk_word(resets - c0, 32'h0000_0001);
		chk_rd(EVD_ADDR_STATUS, 32'h0000_0440, EVD_RESP_OKAY);
		results;
	end
endmodule
